/* File: rtl/etd_pkg.sv */
package etd_pkg;
  // Register byte offsets on the control bus
  localparam logic [7:0] ADDR_NCR = 8'h00;
  localparam logic [7:0] ADDR_NCFG = 8'h04;
  localparam logic [7:0] ADDR_TSR = 8'h14;
  localparam logic [7:0] ADDR_TBQP = 8'h1c;
  // Network control, configuration and transmit status fields
  localparam int unsigned NCR_TX_EN = 3;
  localparam int unsigned NCR_START = 9;
  localparam int unsigned NCR_HALT = 10;
  localparam int unsigned NCFG_PAUSE_EN = 13;
  localparam int unsigned TSR_GO = 3;
  // Descriptor control/status word fields
  localparam int unsigned D_USED = 31;
  localparam int unsigned D_WRAP = 30;
  localparam int unsigned D_RETRY = 29;
  localparam int unsigned D_UNDERRUN = 28;
  localparam int unsigned D_EXHAUST = 27;
  localparam int unsigned D_NO_CRC = 16;
  localparam int unsigned D_LAST = 15;
  localparam int unsigned D_LEN_MSB = 10;
  localparam logic [31:0] D_KEEP_MASK = 32'h4001_87ff;
  // Descriptor list geometry
  localparam int unsigned IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_LAST = 10'h3ff;
  localparam int unsigned DESC_SHIFT = 3;
  localparam logic [31:0] CTRL_OFS = 32'h0000_0004;
  // Pad target: 64-byte minimum frame less the 4 CRC bytes
  localparam int unsigned FLEN_W = 18;
  localparam int unsigned MIN_FRAME = 64;
  localparam int unsigned CRC_BYTES = 4;
  localparam logic [FLEN_W-1:0] PAD_LEN = FLEN_W'(MIN_FRAME - CRC_BYTES);
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Memory end
  localparam int unsigned MEM_AW = 10;
  localparam int unsigned MEM_WORDS = 1024;

  typedef enum logic [3:0] {
    ST_IDLE, ST_RD_CTRL, ST_RD_ADDR, ST_RD_DATA, ST_SEND,
    ST_END_BUF, ST_PAD, ST_EOF, ST_WB
  } etd_state_e;
endpackage : etd_pkg

/* File: rtl/etd_mem_if.sv */
interface etd_mem_if;
  logic req;
  logic we;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic ack;
  logic [31:0] rdata;
  logic err;

  modport dma (output req, we, addr, wdata, input ack, rdata, err);
  modport mem (input req, we, addr, wdata, output ack, rdata, err);
endinterface : etd_mem_if

/* File: rtl/etd_dma.sv */
// Operation
// - Buffers 0..2047 bytes, zero length accepted
// - Software spreads a frame over <=128 buffers
// - Descriptor: address word, then control word
// - Auto-CRC frames padded to 64 bytes
// - Send only from descriptors with used clear
// - Write back status to first descriptor only
// - Status bits 29, 28, 27 report errors
// - Wrap bit or 1024 descriptors restart list
// - Software never rewrites queue pointer mid-transmit
// - Queue pointer write resets index, clears go
// - Transmit disable clears go and index
// - Start bit sets go; rewrite is harmless
// - Go flag readable at status bit 3
// - Halt clears go after current frame
// - Used at frame start: stop, keep pointer
// - Collision restarts from frame's first buffer
// - Used mid-frame: error, tx error, bad FCS
// - Transmit error clears go, resets pointer
// - Control bit 16 suppresses CRC append
// - Bit 15 marks last buffer; reserved bits
// - Pause with pause enable suspends new frames
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
module etd_dma (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  etd_mem_if.dma mem_bus,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic tx_eof_o,
  output logic tx_no_crc_o,
  output logic tx_er_o,
  input wire logic collision_i,
  input wire logic retry_limit_i,
  input wire logic pause_i
);
  import etd_pkg::*;

  etd_state_e state;
  logic tx_en, pause_en, go, halt_pend, in_frame, fail;
  logic start_p, halt_p, qp_wr_p;
  logic [31:0] qbase, ctrl, first_ctrl, baddr, stat, aw_addr_q, w_data_q;
  logic [IDX_W-1:0] idx, first_idx;
  logic [D_LEN_MSB:0] bcnt;
  logic [FLEN_W-1:0] flen;
  logic [7:0] aw_addr;
  logic [7:0] ar_addr;

  function automatic logic [31:0] desc_addr(input logic [31:0] base,
                                            input logic [IDX_W-1:0] i);
    desc_addr = base + {{(32-IDX_W-DESC_SHIFT){1'b0}}, i,
                        {DESC_SHIFT{1'b0}}};
  endfunction : desc_addr

  function automatic logic [IDX_W-1:0] next_idx(input logic [IDX_W-1:0] i,
                                                input logic wrap);
    next_idx = (wrap || i == IDX_LAST) ? '0 : i + 1'b1;
  endfunction : next_idx

  function automatic logic [7:0] lane(input logic [31:0] w,
                                      input logic [1:0] s);
    case (s)
      2'h0: lane = w[7:0];
      2'h1: lane = w[15:8];
      2'h2: lane = w[23:16];
      default: lane = w[31:24];
    endcase
  endfunction : lane

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == ADDR_NCR) || (a == ADDR_NCFG) || (a == ADDR_TSR) ||
              (a == ADDR_TBQP);
  endfunction : reg_hit

  assign aw_addr = aw_addr_q[7:0];

  // AXI4-Lite write channel
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= '0;
      tx_en <= 1'b0;
      pause_en <= 1'b0;
      qbase <= '0;
      start_p <= 1'b0;
      halt_p <= 1'b0;
      qp_wr_p <= 1'b0;
    end else begin
      start_p <= 1'b0;
      halt_p <= 1'b0;
      qp_wr_p <= 1'b0;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_addr_q <= {24'h0, s_axi_awaddr_i};
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_data_q <= s_axi_wdata_i;
        s_axi_wready_o <= 1'b0;
      end
      if (!s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= reg_hit(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        case (aw_addr)
          ADDR_NCR: begin
            tx_en <= w_data_q[NCR_TX_EN];
            start_p <= w_data_q[NCR_START];
            halt_p <= w_data_q[NCR_HALT];
          end
          ADDR_NCFG: pause_en <= w_data_q[NCFG_PAUSE_EN];
          ADDR_TBQP: begin
            qbase <= w_data_q;
            qp_wr_p <= 1'b1;
          end
          default: ;
        endcase
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
      ar_addr <= '0;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        ar_addr <= s_axi_araddr_i;
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= reg_hit(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
        case (s_axi_araddr_i)
          ADDR_NCR: s_axi_rdata_o <= 32'(tx_en) << NCR_TX_EN;
          ADDR_NCFG: s_axi_rdata_o <= 32'(pause_en) << NCFG_PAUSE_EN;
          ADDR_TSR: s_axi_rdata_o <= 32'(go) << TSR_GO;
          ADDR_TBQP: s_axi_rdata_o <= desc_addr(qbase, idx);
          default: s_axi_rdata_o <= '0;
        endcase
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // Descriptor walker and frame streamer
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_IDLE;
      go <= 1'b0;
      halt_pend <= 1'b0;
      in_frame <= 1'b0;
      fail <= 1'b0;
      idx <= '0;
      first_idx <= '0;
      ctrl <= '0;
      first_ctrl <= '0;
      baddr <= '0;
      bcnt <= '0;
      flen <= '0;
      stat <= '0;
      mem_bus.req <= 1'b0;
      mem_bus.we <= 1'b0;
      mem_bus.addr <= '0;
      mem_bus.wdata <= '0;
      tx_data_o <= '0;
      tx_valid_o <= 1'b0;
      tx_eof_o <= 1'b0;
      tx_no_crc_o <= 1'b0;
      tx_er_o <= 1'b0;
    end else begin
      tx_eof_o <= 1'b0;
      tx_er_o <= 1'b0;
      if (!tx_en || qp_wr_p) begin
        go <= 1'b0;
        idx <= '0;
        state <= ST_IDLE;
        halt_pend <= 1'b0;
        mem_bus.req <= 1'b0;
        tx_valid_o <= 1'b0;
      end else begin
        if (halt_p) begin
          halt_pend <= 1'b1;
        end
        if (start_p) begin
          go <= 1'b1;
          halt_pend <= 1'b0;
        end
        case (state)
          ST_IDLE: begin
            if (halt_pend && !start_p) begin
              go <= 1'b0;
              halt_pend <= 1'b0;
            end else if (go && !(pause_en && pause_i)) begin
              mem_bus.req <= 1'b1;
              mem_bus.we <= 1'b0;
              mem_bus.addr <= desc_addr(qbase, idx) + CTRL_OFS;
              first_idx <= idx;
              in_frame <= 1'b0;
              fail <= 1'b0;
              flen <= '0;
              stat <= '0;
              state <= ST_RD_CTRL;
            end
          end
          ST_RD_CTRL: if (mem_bus.ack) begin
            mem_bus.req <= 1'b0;
            if (mem_bus.err) begin
              stat <= 32'h1 << D_UNDERRUN;
              fail <= 1'b1;
              state <= ST_EOF;
            end else if (mem_bus.rdata[D_USED]) begin
              if (in_frame) begin
                stat <= (32'h1 << D_UNDERRUN) | (32'h1 << D_EXHAUST);
                fail <= 1'b1;
                state <= ST_EOF;
              end else begin
                go <= start_p;
                state <= ST_IDLE;
              end
            end else begin
              ctrl <= mem_bus.rdata;
              if (!in_frame) begin
                first_ctrl <= mem_bus.rdata;
              end
              mem_bus.req <= 1'b1;
              mem_bus.addr <= desc_addr(qbase, idx);
              state <= ST_RD_ADDR;
            end
          end
          ST_RD_ADDR: if (mem_bus.ack) begin
            mem_bus.req <= 1'b0;
            bcnt <= '0;
            baddr <= mem_bus.rdata;
            if (mem_bus.err) begin
              stat <= 32'h1 << D_UNDERRUN;
              fail <= 1'b1;
              state <= ST_EOF;
            end else if (ctrl[D_LEN_MSB:0] == '0) begin
              state <= ST_END_BUF;
            end else begin
              mem_bus.req <= 1'b1;
              mem_bus.addr <= {mem_bus.rdata[31:2], 2'h0};
              state <= ST_RD_DATA;
            end
          end
          ST_RD_DATA: if (mem_bus.ack) begin
            mem_bus.req <= 1'b0;
            if (mem_bus.err) begin
              stat <= 32'h1 << D_UNDERRUN;
              fail <= 1'b1;
              state <= ST_EOF;
            end else begin
              tx_data_o <= lane(mem_bus.rdata, baddr[1:0]);
              tx_valid_o <= 1'b1;
              state <= ST_SEND;
            end
          end
          ST_SEND: begin
            if (collision_i) begin
              tx_valid_o <= 1'b0;
              idx <= first_idx;
              in_frame <= 1'b0;
              flen <= '0;
              mem_bus.req <= 1'b1;
              mem_bus.addr <= desc_addr(qbase, first_idx) + CTRL_OFS;
              state <= ST_RD_CTRL;
            end else if (retry_limit_i) begin
              tx_valid_o <= 1'b0;
              stat <= 32'h1 << D_RETRY;
              fail <= 1'b1;
              state <= ST_EOF;
            end else if (tx_ready_i) begin
              tx_valid_o <= 1'b0;
              flen <= flen + 1'b1;
              bcnt <= bcnt + 1'b1;
              baddr <= baddr + 32'h1;
              if (bcnt + 1'b1 == ctrl[D_LEN_MSB:0]) begin
                state <= ST_END_BUF;
              end else begin
                mem_bus.req <= 1'b1;
                mem_bus.addr <= {baddr[31:2] + 30'(&baddr[1:0]), 2'h0};
                state <= ST_RD_DATA;
              end
            end
          end
          ST_END_BUF: begin
            idx <= next_idx(idx, ctrl[D_WRAP]);
            if (ctrl[D_LAST]) begin
              if (!ctrl[D_NO_CRC] && flen < PAD_LEN) begin
                tx_data_o <= '0;
                tx_valid_o <= 1'b1;
                state <= ST_PAD;
              end else begin
                state <= ST_EOF;
              end
            end else begin
              in_frame <= 1'b1;
              mem_bus.req <= 1'b1;
              mem_bus.addr <= desc_addr(qbase, next_idx(idx, ctrl[D_WRAP]))
                              + CTRL_OFS;
              state <= ST_RD_CTRL;
            end
          end
          ST_PAD: if (tx_ready_i) begin
            flen <= flen + 1'b1;
            if (flen + 1'b1 >= PAD_LEN) begin
              tx_valid_o <= 1'b0;
              state <= ST_EOF;
            end
          end
          ST_EOF: begin
            tx_eof_o <= 1'b1;
            tx_no_crc_o <= ctrl[D_NO_CRC];
            tx_er_o <= fail;
            mem_bus.req <= 1'b1;
            mem_bus.we <= 1'b1;
            mem_bus.addr <= desc_addr(qbase, first_idx) + CTRL_OFS;
            mem_bus.wdata <= (first_ctrl & D_KEEP_MASK) | stat |
                             (32'h1 << D_USED);
            state <= ST_WB;
          end
          ST_WB: if (mem_bus.ack) begin
            mem_bus.req <= 1'b0;
            mem_bus.we <= 1'b0;
            if (fail) begin
              go <= start_p;
              idx <= '0;
            end
            state <= ST_IDLE;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule : etd_dma

/* File: rtl/etd_mem.sv */
module etd_mem (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  etd_mem_if.mem mem_bus,
  input wire logic user_we_i,
  input wire logic [etd_pkg::MEM_AW-1:0] user_addr_i,
  input wire logic [31:0] user_wdata_i,
  output logic [31:0] user_rdata_o
);
  import etd_pkg::*;

  logic [31:0] mem [MEM_WORDS];
  logic in_range;
  logic [MEM_AW-1:0] widx;

  assign widx = mem_bus.addr[MEM_AW+1:2];
  assign in_range = mem_bus.addr[31:MEM_AW+2] == '0;

  // Storage; the bus side wins a same-word clash with the user side
  always_ff @(posedge clk_sys_i) begin
    if (user_we_i) begin
      mem[user_addr_i] <= user_wdata_i;
    end
    if (mem_bus.req && !mem_bus.ack && mem_bus.we && in_range) begin
      mem[widx] <= mem_bus.wdata;
    end
  end

  // One answer per request, one cycle after it is seen
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_bus.ack <= 1'b0;
      mem_bus.err <= 1'b0;
      mem_bus.rdata <= '0;
      user_rdata_o <= '0;
    end else begin
      mem_bus.ack <= mem_bus.req && !mem_bus.ack;
      mem_bus.err <= mem_bus.req && !mem_bus.ack && !in_range;
      mem_bus.rdata <= in_range ? mem[widx] : '0;
      user_rdata_o <= mem[user_addr_i];
    end
  end
endmodule : etd_mem

/* File: verif/etd_bus_monitor.sv */
module etd_bus_monitor (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic req,
  input wire logic we,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic ack,
  input wire logic [31:0] rdata,
  input wire logic err
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);
  property p_ack;
    req && !ack |=> ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("no ack one cycle after request");
  property p_ack_pulse;
    ack |=> !ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  // A request may follow its ack directly, but only for a new word
  property p_req_drop;
    ack |=> !req || $changed(addr);
  endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("request repeated after ack");
  property p_hold;
    req && !ack |=> $stable(addr) && $stable(we) && $stable(wdata);
  endproperty
  a_hold: assert property (p_hold)
    else $error("request changed before ack");
  property p_err_ack;
    err |-> ack;
  endproperty
  a_err_ack: assert property (p_err_ack)
    else $error("err without ack");
  property p_range;
    req && !ack |=> (err == ($past(addr) > 32'hffc));
  endproperty
  a_range: assert property (p_range)
    else $error("err does not match address range");
  property p_wb_used;
    req && we |-> wdata[31];
  endproperty
  a_wb_used: assert property (p_wb_used)
    else $error("write-back without used bit");
  property p_wb_rsvd;
    req && we |-> (wdata & 32'h07fe_7800) == 32'h0;
  endproperty
  a_wb_rsvd: assert property (p_wb_rsvd)
    else $error("write-back sets reserved bits");
endmodule : etd_bus_monitor

/* File: verif/eth_tx_descriptor_dma_bench.sv */
module eth_tx_descriptor_dma_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import etd_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic rdy = 1'b1;
  logic coll = 1'b0;
  logic retry = 1'b0;
  logic pse = 1'b0;
  logic uwe = 1'b0;
  logic [9:0] uaddr = 10'h0;
  logic [31:0] uwdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, txv, eof, nc, er;
  logic [1:0] bresp, rresp, lresp;
  logic [31:0] rdata, urdata;
  logic [7:0] txd;
  logic er_seen, nc_seen;
  logic [7:0] q[$];
  int n_fail = 0;
  int checked = 0;

  etd_mem_if mif();
  etd_dma i_etd_dma(.clk_sys_i(clk), .resetn_i(resetn), .mem_bus(mif),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .tx_data_o(txd), .tx_valid_o(txv),
    .tx_ready_i(rdy), .tx_eof_o(eof), .tx_no_crc_o(nc), .tx_er_o(er),
    .collision_i(coll), .retry_limit_i(retry), .pause_i(pse));
  etd_mem i_etd_mem(.clk_sys_i(clk), .resetn_i(resetn), .mem_bus(mif),
    .user_we_i(uwe), .user_addr_i(uaddr), .user_wdata_i(uwdata),
    .user_rdata_o(urdata));
  etd_bus_monitor i_etd_bus_monitor(.clk_sys_i(clk), .resetn_i(resetn),
    .req(mif.req), .we(mif.we), .addr(mif.addr), .wdata(mif.wdata),
    .ack(mif.ack), .rdata(mif.rdata), .err(mif.err));

  initial begin
    forever #50 clk = ~clk;
  end

  // Frame bytes as the far-side MAC takes them
  always @(posedge clk) begin
    if (txv && rdy) begin
      q.push_back(txd);
    end
    if (eof) begin
      er_seen = er;
      nc_seen = nc;
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      n_fail++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    lresp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    lresp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask : rc

  task automatic mw(input int i, input logic [31:0] d);
    @(posedge clk);
    uwe <= 1'b1;
    uaddr <= 10'(i);
    uwdata <= d;
    @(posedge clk);
    uwe <= 1'b0;
  endtask : mw

  task automatic mc(input string nm, input int i, input logic [31:0] e);
    @(posedge clk);
    uaddr <= 10'(i);
    @(posedge clk);
    @(negedge clk);
    chk(nm, e, urdata);
  endtask : mc

  // Descriptor list sits at byte 0x100, word index 64
  task automatic desc(input int i, input logic [31:0] b, c);
    mw(64 + 2 * i, b);
    mw(65 + 2 * i, c);
  endtask : desc

  task automatic run();
    @(negedge clk);
    q.delete();
    er_seen = 1'b0;
    nc_seen = 1'b0;
    wr(ADDR_TBQP, 32'h100);
    wr(ADDR_NCR, 32'h208);
  endtask : run

  task automatic stopw();
    logic [31:0] d;
    do begin
      rd(ADDR_TSR, d);
    end while (d[TSR_GO] !== 1'b0);
  endtask : stopw

  task automatic chkq(input logic [7:0] e[$]);
    chk("count", 32'(e.size()), 32'(q.size()));
    foreach (e[k]) begin
      if (k < q.size()) chk("byte", 32'(e[k]), 32'(q[k]));
    end
  endtask : chkq

  task automatic t_regs();
    wr(8'h08, 32'h0);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, lresp});
    rc("rdata", 8'h08, 32'h0);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, lresp});
    rc("go_reset", ADDR_TSR, 32'h0);
    wr(ADDR_TBQP, 32'h100);
    chk("bresp_ok", {30'h0, RESP_OKAY}, {30'h0, lresp});
    rc("qptr", ADDR_TBQP, 32'h100);
    chk("rresp_ok", {30'h0, RESP_OKAY}, {30'h0, lresp});
    $display("test regs done");
  endtask : t_regs

  task automatic t_frame();
    desc(0, 32'h200, 32'h0010_0003);
    desc(1, 32'h200, 32'h0001_8000);
    desc(2, 32'h200, 32'h8000_8001);
    run();
    stopw();
    chkq('{8'h01, 8'h02, 8'h03});
    chk("no_crc", 32'h1, {31'h0, nc_seen});
    mc("wb0", 65, 32'h8000_0003);
    mc("desc1", 67, 32'h0001_8000);
    rc("qptr_kept", ADDR_TBQP, 32'h110);
    mw(69, 32'h4001_8001);
    wr(ADDR_NCR, 32'h208);
    stopw();
    chkq('{8'h01, 8'h02, 8'h03, 8'h01});
    mc("wb2", 69, 32'hc001_8001);
    rc("qptr_wrap", ADDR_TBQP, 32'h100);
    $display("test frame done");
  endtask : t_frame

  task automatic t_halt();
    logic [7:0] e[$];
    desc(0, 32'h200, 32'h0000_8002);
    desc(1, 32'h200, 32'h0000_8001);
    run();
    while (q.size() == 0) @(negedge clk);
    wr(ADDR_NCR, 32'h408);
    rc("go_busy", ADDR_TSR, 32'h8);
    stopw();
    e = '{8'h01, 8'h02};
    repeat (58) e.push_back(8'h00);
    chkq(e);
    chk("no_crc", 32'h0, {31'h0, nc_seen});
    rc("qptr_halt", ADDR_TBQP, 32'h108);
    wr(ADDR_NCR, 32'h0);
    rc("qptr_off", ADDR_TBQP, 32'h100);
    $display("test halt done");
  endtask : t_halt

  task automatic t_err();
    desc(0, 32'h200, 32'h0000_0001);
    desc(1, 32'h200, 32'h8000_8001);
    run();
    stopw();
    chkq('{8'h01});
    chk("tx_er", 32'h1, {31'h0, er_seen});
    mc("wb_mid", 65, 32'h9800_0001);
    rc("qptr_mid", ADDR_TBQP, 32'h100);
    desc(0, 32'h200, 32'h0001_8002);
    @(posedge clk);
    retry <= 1'b1;
    run();
    stopw();
    @(posedge clk);
    retry <= 1'b0;
    mc("wb_retry", 65, 32'ha001_8002);
    rc("qptr_retry", ADDR_TBQP, 32'h100);
    // Buffer outside memory: the data fetch ends in a bus error
    desc(0, 32'h2000, 32'h0000_8001);
    run();
    stopw();
    chk("tx_er_bus", 32'h1, {31'h0, er_seen});
    mc("wb_bus", 65, 32'h9000_8001);
    rc("qptr_bus", ADDR_TBQP, 32'h100);
    $display("test errors done");
  endtask : t_err

  task automatic t_coll();
    desc(0, 32'h200, 32'h0000_0002);
    desc(1, 32'h204, 32'h0001_8002);
    desc(2, 32'h200, 32'h8000_8000);
    run();
    while (q.size() < 3) @(negedge clk);
    @(posedge clk);
    rdy <= 1'b0;
    coll <= 1'b1;
    do @(posedge clk); while (!txv);
    coll <= 1'b0;
    rdy <= 1'b1;
    stopw();
    chkq('{8'h01, 8'h02, 8'h05, 8'h01, 8'h02, 8'h05, 8'h06});
    mc("wb_coll", 65, 32'h8000_0002);
    $display("test collision done");
  endtask : t_coll

  task automatic t_pause();
    desc(0, 32'h200, 32'h4001_8001);
    wr(ADDR_NCFG, 32'h2000);
    rc("pause_en", ADDR_NCFG, 32'h2000);
    @(posedge clk);
    pse <= 1'b1;
    run();
    repeat (20) @(posedge clk);
    chk("paused", 32'h0, 32'(q.size()));
    rc("go_paused", ADDR_TSR, 32'h8);
    @(posedge clk);
    pse <= 1'b0;
    stopw();
    chkq('{8'h01});
    mc("wb_pause", 65, 32'hc001_8001);
    rc("qptr_pause", ADDR_TBQP, 32'h100);
    $display("test pause done");
  endtask : t_pause

  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    mw(128, 32'h0403_0201);
    mw(129, 32'h0807_0605);
    t_regs();
    t_frame();
    t_halt();
    t_err();
    t_coll();
    t_pause();
    conclude();
  end

  initial begin
    #2000000;
    n_fail++;
    $display("watchdog expired");
    conclude();
  end
endmodule : eth_tx_descriptor_dma_bench
